// ===== hw/wlou_regs.svh
`ifndef WLOU_REGS_SVH
`define WLOU_REGS_SVH

// Function codes (three decimal digits, carried as 10-bit binary values)
`define WLOU_FC_AND_SINGLE    10'h022 // 034
`define WLOU_FC_OR_SINGLE     10'h023 // 035
`define WLOU_FC_XOR_SINGLE    10'h024 // 036
`define WLOU_FC_INVERT_SINGLE 10'h01d // 029
`define WLOU_FC_AND_DOUBLE    10'h262 // 610
`define WLOU_FC_OR_DOUBLE     10'h263 // 611
`define WLOU_FC_XOR_DOUBLE    10'h264 // 612
`define WLOU_FC_INVERT_DOUBLE 10'h266 // 614

// Field layout of a double word: lower address word is the low half
`define WLOU_LO_MSB   15
`define WLOU_HI_LSB   16
`define WLOU_WORD_MSB 15
`define WLOU_DWORD_MSB 31
`define WLOU_LO_LSB    0
`define WLOU_WORD_ONES 16'hffff

// Width masks applied to a raw 32-bit result
`define WLOU_MASK_SINGLE 32'h0000_ffff
`define WLOU_MASK_DOUBLE 32'hffff_ffff

// Reset values
`define WLOU_WORD_RST  16'h0000
`define WLOU_DWORD_RST 32'h0000_0000
`define WLOU_FLAG_RST  1'h0

`endif

// ===== hw/wlou_pkg.sv
package wlou_pkg;
  typedef logic [15:0] wlou_word_t;
  typedef logic [31:0] wlou_dword_t;
  typedef logic [9:0]  wlou_code_t;
  typedef enum logic [2:0] {
    WLOU_OP_NONE,
    WLOU_OP_AND,
    WLOU_OP_OR,
    WLOU_OP_XOR,
    WLOU_OP_INVERT
  } wlou_op_e;
endpackage

// ===== hw/wlou_flag_gen.sv
`timescale 1ns/1ps
`include "wlou_regs.svh"
// Flag evaluation for a 16- or 32-bit logic result
module wlou_flag_gen
  import wlou_pkg::*;
(
  input  wire logic        is_double,
  input  wire wlou_dword_t result,
  output logic             zero,
  output logic             negative
);
  wire wlou_word_t upper_half;

  assign upper_half = is_double ? result[`WLOU_DWORD_MSB:`WLOU_HI_LSB] : `WLOU_WORD_RST;
  assign zero       = (result[`WLOU_LO_MSB:`WLOU_LO_LSB] == `WLOU_WORD_RST) && (upper_half == `WLOU_WORD_RST);
  assign negative   = is_double ? result[`WLOU_DWORD_MSB] : result[`WLOU_WORD_MSB];
endmodule // wlou_flag_gen

// ===== hw/wlou_logic_unit.sv
`timescale 1ns/1ps
`include "wlou_regs.svh"
// Notes on behaviour
// - code 034 ANDs two single words
// - code 610 ANDs two double words
// - code 035 ORs two single words
// - code 611 ORs two double words
// - code 036 XORs two single words
// - code 612 XORs two double words
// - code 029 inverts target word in place
// - code 614 inverts target double word
// - equals on zero result; error always cleared
// - negative follows result most significant bit
// - invert repeats every cycle condition holds
module wlou_logic_unit
  import wlou_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       exec_cond,
  input  wire wlou_code_t func_code,
  input  wire wlou_word_t first_input_lo,
  input  wire wlou_word_t first_input_hi,
  input  wire wlou_word_t second_input_lo,
  input  wire wlou_word_t second_input_hi,
  input  wire wlou_word_t target_word_lo,
  input  wire wlou_word_t target_word_hi,
  output logic            result_valid,
  output logic            result_double,
  output wlou_word_t      result_lo,
  output wlou_word_t      result_hi,
  output logic            write_back_target,
  output logic            equals_flag,
  output logic            negative_flag,
  output logic            error_flag,
  output logic            code_unknown
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic wlou_op_e decode_op(input wlou_code_t code);
    case (code)
      `WLOU_FC_AND_SINGLE, `WLOU_FC_AND_DOUBLE:       decode_op = WLOU_OP_AND;
      `WLOU_FC_OR_SINGLE, `WLOU_FC_OR_DOUBLE:         decode_op = WLOU_OP_OR;
      `WLOU_FC_XOR_SINGLE, `WLOU_FC_XOR_DOUBLE:       decode_op = WLOU_OP_XOR;
      `WLOU_FC_INVERT_SINGLE, `WLOU_FC_INVERT_DOUBLE: decode_op = WLOU_OP_INVERT;
      default:                                        decode_op = WLOU_OP_NONE;
    endcase
  endfunction

  wire wlou_op_e    op_sel;
  wire logic        is_double;
  wire logic        op_known;
  wire wlou_dword_t first_in;
  wire wlou_dword_t second_in;
  wire wlou_dword_t target_in;
  wire wlou_dword_t width_mask;

  assign op_sel     = decode_op(func_code);
  assign op_known   = (op_sel != WLOU_OP_NONE);
  assign is_double  = (func_code == `WLOU_FC_AND_DOUBLE) || (func_code == `WLOU_FC_OR_DOUBLE) ||
                      (func_code == `WLOU_FC_XOR_DOUBLE) || (func_code == `WLOU_FC_INVERT_DOUBLE);
  // Lower address word is the least significant half, on every operand
  assign first_in   = {first_input_hi, first_input_lo};
  assign second_in  = {second_input_hi, second_input_lo};
  assign target_in  = {target_word_hi, target_word_lo};
  // Single-word results keep the upper half clear so flags see only 16 bits
  assign width_mask = is_double ? `WLOU_MASK_DOUBLE : `WLOU_MASK_SINGLE;

  // ---------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------
  logic [31:0] raw_result;
  always_comb begin
    case (op_sel)
      WLOU_OP_AND:    raw_result = first_in & second_in;
      WLOU_OP_OR:     raw_result = first_in | second_in;
      WLOU_OP_XOR:    raw_result = first_in ^ second_in;
      WLOU_OP_INVERT: raw_result = ~target_in;
      default:        raw_result = `WLOU_DWORD_RST;
    endcase
  end

  wire wlou_dword_t nxt_result;
  wire logic        res_zero;
  wire logic        res_neg;
  wire logic        fire;

  assign nxt_result = raw_result & width_mask;
  assign fire       = exec_cond && op_known;

  wlou_flag_gen u_flags (
    .is_double (is_double),
    .result    (nxt_result),
    .zero      (res_zero),
    .negative  (res_neg)
  );

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  wlou_dword_t result_ff;
  logic        valid_ff;
  logic        double_ff;
  logic        invert_ff;
  logic        eq_ff;
  logic        neg_ff;
  logic        unk_ff;

  // No edge qualification here: the sequencer owns one-shot behaviour
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_ff <= {`WLOU_WORD_RST, `WLOU_WORD_RST};
      valid_ff  <= `WLOU_FLAG_RST;
      double_ff <= `WLOU_FLAG_RST;
      invert_ff <= `WLOU_FLAG_RST;
      unk_ff    <= `WLOU_FLAG_RST;
    end else begin
      valid_ff  <= fire;
      unk_ff    <= exec_cond && !op_known;
      if (fire) begin
        result_ff <= nxt_result;
        double_ff <= is_double;
        invert_ff <= (op_sel == WLOU_OP_INVERT);
      end
    end
  end

  // Flags hold their last value between executions
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eq_ff  <= `WLOU_FLAG_RST;
      neg_ff <= `WLOU_FLAG_RST;
    end else if (fire) begin
      eq_ff  <= res_zero;
      neg_ff <= res_neg;
    end
  end

  assign result_valid      = valid_ff;
  assign result_double     = double_ff;
  assign result_lo         = result_ff[`WLOU_LO_MSB:0];
  assign result_hi         = result_ff[`WLOU_DWORD_MSB:`WLOU_HI_LSB];
  assign write_back_target = valid_ff && invert_ff;
  assign equals_flag       = eq_ff;
  assign negative_flag     = neg_ff;
  assign error_flag        = `WLOU_FLAG_RST;
  assign code_unknown      = unk_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_fire_code(logic [9:0] c);
    exec_cond && func_code == c;
  endsequence

  chk_and_single: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_AND_SINGLE) |=> result_lo == ($past(first_input_lo) & $past(second_input_lo))
      && result_hi == 16'h0000)
    else $error("single AND result wrong");

  chk_and_double: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_AND_DOUBLE) |=> result_hi == ($past(first_input_hi) & $past(second_input_hi))
      && result_lo == ($past(first_input_lo) & $past(second_input_lo)))
    else $error("double AND result wrong");

  chk_or_single: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_OR_SINGLE) |=> result_lo == ($past(first_input_lo) | $past(second_input_lo)))
    else $error("single OR result wrong");

  chk_or_double: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_OR_DOUBLE) |=> result_hi == ($past(first_input_hi) | $past(second_input_hi))
      && result_double)
    else $error("double OR result wrong");

  chk_xor_single: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_XOR_SINGLE) |=> result_lo == ($past(first_input_lo) ^ $past(second_input_lo)))
    else $error("single XOR result wrong");

  chk_xor_double: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_XOR_DOUBLE) |=> result_hi == ($past(first_input_hi) ^ $past(second_input_hi)))
    else $error("double XOR result wrong");

  chk_invert_single: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_INVERT_SINGLE) |=> write_back_target && result_lo == ~$past(target_word_lo))
    else $error("single invert wrong");

  chk_invert_double: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_INVERT_DOUBLE) |=> write_back_target && result_hi == ~$past(target_word_hi)
      && result_lo == ~$past(target_word_lo))
    else $error("double invert wrong");

  chk_equals_zero: assert property (@(posedge clk) disable iff (sys_rst)
    result_valid |-> equals_flag == (result_lo == 16'h0000 && result_hi == 16'h0000) && !error_flag)
    else $error("equals flag wrong");

  chk_negative_msb: assert property (@(posedge clk) disable iff (sys_rst)
    result_valid |-> negative_flag == (result_double ? result_hi[`WLOU_WORD_MSB] : result_lo[`WLOU_WORD_MSB]))
    else $error("negative flag wrong");

  chk_invert_repeat: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_INVERT_SINGLE) [*2] |=> write_back_target)
    else $error("held condition did not invert again");

  // ---------------------------------------------------------------
  // Operation classes seen at the sequencer side
  // ---------------------------------------------------------------
  // Classes are spelled out from the codes, not from decode_op, so a decode slip shows up
  sequence s_fire_single;
    exec_cond && (func_code == `WLOU_FC_AND_SINGLE || func_code == `WLOU_FC_OR_SINGLE ||
                  func_code == `WLOU_FC_XOR_SINGLE || func_code == `WLOU_FC_INVERT_SINGLE);
  endsequence

  sequence s_fire_double;
    exec_cond && (func_code == `WLOU_FC_AND_DOUBLE || func_code == `WLOU_FC_OR_DOUBLE ||
                  func_code == `WLOU_FC_XOR_DOUBLE || func_code == `WLOU_FC_INVERT_DOUBLE);
  endsequence

  sequence s_fire_logic;
    exec_cond && (func_code == `WLOU_FC_AND_SINGLE || func_code == `WLOU_FC_AND_DOUBLE ||
                  func_code == `WLOU_FC_OR_SINGLE || func_code == `WLOU_FC_OR_DOUBLE ||
                  func_code == `WLOU_FC_XOR_SINGLE || func_code == `WLOU_FC_XOR_DOUBLE);
  endsequence

  sequence s_fire_unknown;
    exec_cond && func_code != `WLOU_FC_AND_SINGLE && func_code != `WLOU_FC_AND_DOUBLE &&
    func_code != `WLOU_FC_OR_SINGLE && func_code != `WLOU_FC_OR_DOUBLE &&
    func_code != `WLOU_FC_XOR_SINGLE && func_code != `WLOU_FC_XOR_DOUBLE &&
    func_code != `WLOU_FC_INVERT_SINGLE && func_code != `WLOU_FC_INVERT_DOUBLE;
  endsequence

  sequence s_idle;
    !exec_cond;
  endsequence

  sequence s_in_reset;
    sys_rst;
  endsequence

  chk_single_width: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_single |=> result_valid
      && !result_double
      && result_hi == `WLOU_WORD_RST)
    else $error("single-word result not confined to low word");

  chk_double_width: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_double |=> result_valid
      && result_double)
    else $error("double-word result not marked");

  chk_logic_no_wback: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_logic |=> !write_back_target)
    else $error("logic operation asked for a write back");

  chk_unknown_refused: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_unknown |=> code_unknown
      && !result_valid
      && !write_back_target
      && $stable(result_lo)
      && $stable(result_hi)
      && $stable(equals_flag)
      && $stable(negative_flag))
    else $error("unmapped code changed the result");

  chk_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    s_idle |=> !result_valid
      && !write_back_target
      && !code_unknown)
    else $error("output strobe without execution condition");

  chk_idle_hold: assert property (@(posedge clk) disable iff (sys_rst)
    s_idle |=> $stable(result_lo)
      && $stable(result_hi)
      && $stable(result_double)
      && $stable(equals_flag)
      && $stable(negative_flag))
    else $error("result or flags moved while idle");

  chk_strobe_cause: assert property (@(posedge clk) disable iff (sys_rst)
    result_valid || code_unknown |-> $past(exec_cond))
    else $error("strobe with no execution condition before it");

  chk_reset_clear: assert property (@(posedge clk)
    s_in_reset |=> !result_valid
      && !code_unknown
      && !write_back_target
      && !result_double
      && !equals_flag
      && !negative_flag
      && result_lo == `WLOU_WORD_RST
      && result_hi == `WLOU_WORD_RST)
    else $error("outputs not cleared by reset");

  chk_invert_double_repeat: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_INVERT_DOUBLE) [*2] |=> write_back_target
      && result_double
      && result_hi == ~$past(target_word_hi))
    else $error("held condition did not invert the double word again");

  chk_or_double_lo: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_OR_DOUBLE) |=> result_lo == ($past(first_input_lo) | $past(second_input_lo)))
    else $error("double OR low word wrong");

  chk_xor_double_lo: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_XOR_DOUBLE) |=> result_lo == ($past(first_input_lo) ^ $past(second_input_lo)))
    else $error("double XOR low word wrong");

  chk_and_double_sign: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_AND_DOUBLE) |=> negative_flag == ($past(first_input_hi[`WLOU_WORD_MSB])
      & $past(second_input_hi[`WLOU_WORD_MSB])))
    else $error("double AND sign flag wrong");

  chk_or_single_sign: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_OR_SINGLE) |=> negative_flag == ($past(first_input_lo[`WLOU_WORD_MSB])
      | $past(second_input_lo[`WLOU_WORD_MSB])))
    else $error("single OR sign flag wrong");

  chk_xor_double_zero: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_XOR_DOUBLE) |=> equals_flag == ($past(first_input_lo) == $past(second_input_lo)
      && $past(first_input_hi) == $past(second_input_hi)))
    else $error("double XOR equals flag wrong");

  chk_invert_single_zero: assert property (@(posedge clk) disable iff (sys_rst)
    s_fire_code(`WLOU_FC_INVERT_SINGLE) |=> equals_flag == ($past(target_word_lo) == `WLOU_WORD_ONES))
    else $error("single invert equals flag wrong");

endmodule // wlou_logic_unit

// ===== tb/wlou_seq_model.sv
`timescale 1ns/1ps
module wlou_seq_model
  import wlou_pkg::*;
(
  input  wire logic clk,
  output logic       exec_cond,
  output wlou_code_t func_code,
  output wlou_word_t a_lo,
  output wlou_word_t a_hi,
  output wlou_word_t b_lo,
  output wlou_word_t b_hi,
  output wlou_word_t t_lo,
  output wlou_word_t t_hi
);
  initial begin
    exec_cond = 1'b0;
    func_code = '0;
    {a_hi, a_lo, b_hi, b_lo, t_hi, t_lo} = '0;
  end
  // Condition is raised and left high, so each call holds its code one cycle and an invert runs once per call
  task automatic issue(input wlou_code_t c, input wlou_dword_t a, input wlou_dword_t b, input wlou_dword_t t);
    @(posedge clk);
    exec_cond <= 1'b1;
    func_code <= c;
    {a_hi, a_lo} <= a;
    {b_hi, b_lo} <= b;
    {t_hi, t_lo} <= t;
  endtask
  // First and second operands are scrambled when idle so stale data never looks valid
  task automatic idle();
    @(posedge clk);
    exec_cond <= 1'b0;
    {a_hi, a_lo, b_hi, b_lo} <= ~{a_hi, a_lo, b_hi, b_lo};
  endtask
endmodule // wlou_seq_model

// ===== tb/word_logic_ops_unit_test.sv
`timescale 1ns/1ps
`include "wlou_regs.svh"
module word_logic_ops_unit_test
  import wlou_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        exec_cond, result_valid, result_double, write_back_target;
  logic        equals_flag, negative_flag, error_flag, code_unknown;
  wlou_code_t  func_code;
  wlou_word_t  a_lo, a_hi, b_lo, b_hi, t_lo, t_hi, result_lo, result_hi;
  logic [38:0] exp_q[$];
  logic [35:0] last = '0;
  int          n_errors = 0;
  int          cmp_count = 0;
  wlou_code_t  codes[8] = '{`WLOU_FC_AND_SINGLE, `WLOU_FC_AND_DOUBLE, `WLOU_FC_OR_SINGLE, `WLOU_FC_OR_DOUBLE,
                            `WLOU_FC_XOR_SINGLE, `WLOU_FC_XOR_DOUBLE, `WLOU_FC_INVERT_SINGLE, `WLOU_FC_INVERT_DOUBLE};
  wire  [38:0] seen = {code_unknown, result_valid, write_back_target, result_double, error_flag,
                       negative_flag, equals_flag, result_hi, result_lo};
  always #12.5 clk = ~clk;
  wlou_seq_model u_wlou_seq_model (.clk(clk), .exec_cond(exec_cond), .func_code(func_code), .a_lo(a_lo),
    .a_hi(a_hi), .b_lo(b_lo), .b_hi(b_hi), .t_lo(t_lo), .t_hi(t_hi));
  wlou_logic_unit u_wlou_logic_unit (.clk(clk), .sys_rst(sys_rst), .exec_cond(exec_cond), .func_code(func_code),
    .first_input_lo(a_lo), .first_input_hi(a_hi), .second_input_lo(b_lo), .second_input_hi(b_hi),
    .target_word_lo(t_lo), .target_word_hi(t_hi), .result_valid(result_valid), .result_double(result_double),
    .result_lo(result_lo), .result_hi(result_hi), .write_back_target(write_back_target),
    .equals_flag(equals_flag), .negative_flag(negative_flag), .error_flag(error_flag),
    .code_unknown(code_unknown));
  task automatic chk(input logic [38:0] s, input logic [38:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic op(input wlou_code_t c, input wlou_dword_t a, input wlou_dword_t b, input wlou_dword_t t);
    logic [31:0] r;
    logic        d, u, w;
    {d, u, w, r} = '0;
    case (c)
      `WLOU_FC_AND_SINGLE:    r = a & b & 32'h0000ffff;
      `WLOU_FC_OR_SINGLE:     r = (a | b) & 32'h0000ffff;
      `WLOU_FC_XOR_SINGLE:    r = (a ^ b) & 32'h0000ffff;
      `WLOU_FC_INVERT_SINGLE: {w, r} = {1'b1, ~t & 32'h0000ffff};
      `WLOU_FC_AND_DOUBLE:    {d, r} = {1'b1, a & b};
      `WLOU_FC_OR_DOUBLE:     {d, r} = {1'b1, a | b};
      `WLOU_FC_XOR_DOUBLE:    {d, r} = {1'b1, a ^ b};
      `WLOU_FC_INVERT_DOUBLE: {d, w, r} = {2'b11, ~t};
      default:                u = 1'b1;
    endcase
    if (!u) last = {d, 1'b0, d ? r[31] : r[15], r == 32'h0, r[31:16], r[15:0]};
    exp_q.push_back({u, ~u, w, last});
    u_wlou_seq_model.issue(c, a, b, t);
  endtask
  // Every result or refusal pulse consumes the oldest expectation
  always @(posedge clk) begin
    if (!sys_rst && (result_valid === 1'b1 || code_unknown === 1'b1)) begin
      if (exp_q.size() == 0) chk(seen, 'x);
      else chk(seen, exp_q.pop_front());
    end
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #20us;
    n_errors++;
    final_report();
  end
  initial begin
    void'($urandom(71009));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (codes[i]) op(codes[i], $urandom, $urandom, $urandom);
    $display("test all codes back to back done");
    op(`WLOU_FC_AND_DOUBLE, 32'hffff0000, 32'h0000ffff, 0);
    op(`WLOU_FC_XOR_SINGLE, 32'h00008000, 32'h0, 0);
    op(`WLOU_FC_OR_DOUBLE, 32'h80000000, 32'h00008000, 0);
    op(`WLOU_FC_OR_SINGLE, 32'hffff0001, 32'h80000000, 0);
    $display("test zero and sign boundaries done");
    // Held condition: the second invert of each width takes the first one's inverted value back in
    op(`WLOU_FC_INVERT_DOUBLE, 0, 0, 32'h0000ffff);
    op(`WLOU_FC_INVERT_DOUBLE, 0, 0, 32'hffff0000);
    op(`WLOU_FC_INVERT_SINGLE, 0, 0, 32'h1234ffff);
    op(`WLOU_FC_INVERT_SINGLE, 0, 0, 32'h0000_0000);
    $display("test repeated invert done");
    op(10'h3ff, $urandom, $urandom, $urandom);
    op(10'h000, $urandom, $urandom, $urandom);
    u_wlou_seq_model.idle();
    repeat (2) @(posedge clk);
    $display("test unmapped codes done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(seen, '0);
    last = '0;
    @(posedge clk) sys_rst <= 1'b0;
    op(`WLOU_FC_AND_SINGLE, $urandom, $urandom, 0);
    u_wlou_seq_model.idle();
    repeat (3) @(posedge clk);
    chk(39'(exp_q.size()), '0);
    $display("test reset in mid run done");
    final_report();
  end
endmodule // word_logic_ops_unit_test
